// *** ict_pkg.sv ***
// Shared constants, types and helpers for the instruction cycle timing block.
package ict_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ICT_NREG_W = 4;
  localparam int ICT_COST_W = 5;

  // ----------------------------------------------------------------
  // Cycle costs
  // ----------------------------------------------------------------
  localparam logic [ICT_COST_W-1:0] ICT_CYC_ZERO       = 5'h00;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_ONE        = 5'h01;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_LDST       = 5'h02;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_MULTI_BASE = 5'h01;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_POPRET_BASE = 5'h04;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_BR_TAKEN   = 5'h03;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_BR_NOT     = 5'h01;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_BRANCH     = 5'h03;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_BR_LINK    = 5'h04;
  localparam logic [ICT_COST_W-1:0] ICT_CYC_SLEEP      = 5'h02;
  localparam int                    ICT_SVC_DEFAULT    = 4;
  localparam int                    ICT_COST_MAX       = 31;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ICT_ALU, ICT_EXTEND, ICT_ADDR_PC, ICT_ADDR_SP, ICT_LDST, ICT_MULTI,
    ICT_POP_RET, ICT_BR_COND, ICT_BR_UNCOND, ICT_BR_REG, ICT_BR_LINK_REG,
    ICT_BR_LINK_IMM, ICT_SLEEP, ICT_SVC
  } ict_class_t;

  typedef enum logic [1:0] {ICT_ST_IDLE, ICT_ST_EXEC, ICT_ST_SLEEP} ict_state_t;

  // Unconditional and register-target branches that share the three cycle cost.
  function automatic logic ict_plain_branch(input ict_class_t c);
    return (c == ICT_BR_UNCOND) || (c == ICT_BR_REG) || (c == ICT_BR_LINK_REG);
  endfunction

endpackage

// *** ict_cost_if.sv ***
// Interface carrying a cost lookup between the sequencer and the cost table.
`timescale 1ns/100ps
interface ict_cost_if;
  import ict_pkg::*;
  ict_class_t              cls;
  logic [ICT_NREG_W-1:0]   nregs;
  logic                    cond_pass;
  logic [ICT_COST_W-1:0]   cost;
  modport req  (output cls, output nregs, output cond_pass, input cost);
  modport calc (input cls, input nregs, input cond_pass, output cost);
endinterface

// *** ict_cost.sv ***
// Cost table: cycles an instruction class occupies the core.
`timescale 1ns/100ps
module ict_cost #(
  parameter int SVC_CYCLES = ict_pkg::ICT_SVC_DEFAULT
) (
  ict_cost_if.calc c
);
  import ict_pkg::*;

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  // Turns class, register count and condition into a cycle count.
  always_comb begin
    case (c.cls)
      ICT_LDST:        c.cost = ICT_CYC_LDST;
      ICT_MULTI:       c.cost = ICT_CYC_MULTI_BASE + {1'b0, c.nregs};
      ICT_POP_RET:     c.cost = ICT_CYC_POPRET_BASE + {1'b0, c.nregs};
      ICT_BR_COND:     c.cost = c.cond_pass ? ICT_CYC_BR_TAKEN : ICT_CYC_BR_NOT;
      ICT_BR_UNCOND,
      ICT_BR_REG,
      ICT_BR_LINK_REG: c.cost = ICT_CYC_BRANCH;
      ICT_BR_LINK_IMM: c.cost = ICT_CYC_BR_LINK;
      ICT_SLEEP:       c.cost = ICT_CYC_SLEEP;
      ICT_SVC:         c.cost = SVC_CYCLES[ICT_COST_W-1:0];
      default:         c.cost = ICT_CYC_ONE;
    endcase
  end

endmodule

// *** ict_timer.sv ***
// Issue sequencer that holds each instruction for its documented cycle count.
`timescale 1ns/100ps
module ict_timer #(
  parameter int SVC_CYCLES = ict_pkg::ICT_SVC_DEFAULT
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          issue_valid,
  input  wire ict_pkg::ict_class_t           issue_class,
  input  wire logic [ict_pkg::ICT_NREG_W-1:0] issue_nregs,
  input  wire logic                          cond_pass,
  input  wire logic                          wake,
  output logic                               issue_ready,
  output logic                               retire,
  output ict_pkg::ict_class_t                retire_class,
  output logic [ict_pkg::ICT_COST_W-1:0]     retire_cycles,
  output logic                               sleeping
);
  import ict_pkg::*;

  // ----------------------------------------------------------------
  // Configuration check
  // ----------------------------------------------------------------
  if (SVC_CYCLES < 1 || SVC_CYCLES > ICT_COST_MAX) begin : g_bad_svc
    $error("SVC_CYCLES must lie between 1 and 31.");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ict_state_t            st;
    logic [ICT_COST_W-1:0] cnt;
    logic                  ready;
    logic                  retire;
    logic                  sleeping;
    ict_class_t            cur_cls;
    logic [ICT_COST_W-1:0] cur_cost;
    ict_class_t            ret_cls;
    logic [ICT_COST_W-1:0] ret_cyc;
  } ict_seq_t;

  ict_seq_t s_r;
  ict_seq_t s_nxt;
  logic     accept;

  ict_cost_if cif ();

  // ----------------------------------------------------------------
  // Cost lookup
  // ----------------------------------------------------------------
  // The table sees the offered instruction directly.
  assign cif.cls       = issue_class;
  assign cif.nregs     = issue_nregs;
  assign cif.cond_pass = cond_pass;

  ict_cost #(.SVC_CYCLES(SVC_CYCLES)) u_cost (.c(cif));

  // Only an idle core takes a new instruction.
  assign accept = issue_valid && s_r.ready;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Counts down the occupied cycles and parks in sleep until a wake.
  always_comb begin
    logic done;
    done          = 1'b0;
    s_nxt         = s_r;
    s_nxt.retire  = 1'b0;
    case (s_r.st)
      ICT_ST_IDLE: begin
        if (accept) begin
          s_nxt.cur_cls  = issue_class;
          s_nxt.cur_cost = cif.cost;
          if (cif.cost == ICT_CYC_ONE) begin
            s_nxt.retire  = 1'b1;
            s_nxt.ret_cls = issue_class;
            s_nxt.ret_cyc = cif.cost;
          end else begin
            s_nxt.st    = ICT_ST_EXEC;
            s_nxt.cnt   = cif.cost - ICT_CYC_LDST;
            s_nxt.ready = 1'b0;
          end
        end
      end
      ICT_ST_EXEC: begin
        if (s_r.cnt != ICT_CYC_ZERO) begin
          s_nxt.cnt = s_r.cnt - ICT_CYC_ONE;
        end else if (s_r.cur_cls == ICT_SLEEP && !wake) begin
          s_nxt.st       = ICT_ST_SLEEP;
          s_nxt.sleeping = 1'b1;
        end else begin
          done = 1'b1;
        end
      end
      ICT_ST_SLEEP: begin
        done = wake;
      end
      default: begin
        s_nxt.st = ICT_ST_IDLE;
      end
    endcase
    if (done) begin
      s_nxt.st       = ICT_ST_IDLE;
      s_nxt.ready    = 1'b1;
      s_nxt.retire   = 1'b1;
      s_nxt.sleeping = 1'b0;
      s_nxt.ret_cls  = s_r.cur_cls;
      s_nxt.ret_cyc  = s_r.cur_cost;
    end
  end

  // Registers the whole sequencer state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '{st: ICT_ST_IDLE, cnt: ICT_CYC_ZERO, ready: 1'b1, retire: 1'b0,
               sleeping: 1'b0, cur_cls: ICT_ALU, cur_cost: ICT_CYC_ZERO,
               ret_cls: ICT_ALU, ret_cyc: ICT_CYC_ZERO};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign issue_ready   = s_r.ready;
  assign retire        = s_r.retire;
  assign retire_class  = s_r.ret_cls;
  assign retire_cycles = s_r.ret_cyc;
  assign sleeping      = s_r.sleeping;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ict_class_t            h_cls;
  logic [ICT_NREG_W-1:0] h_n;
  logic                  h_cond;
  logic [ICT_COST_W-1:0] span_r;

  // Records the last accepted instruction and counts its active cycles.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      h_cls  <= ICT_ALU;
      h_n    <= '0;
      h_cond <= 1'b0;
      span_r <= ICT_CYC_ZERO;
    end else if (accept) begin
      h_cls  <= issue_class;
      h_n    <= issue_nregs;
      h_cond <= cond_pass;
      span_r <= ICT_CYC_ONE;
    end else if (s_r.st == ICT_ST_EXEC) begin
      span_r <= span_r + ICT_CYC_ONE;
    end
  end

  a_alu_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    retire && h_cls == ICT_ALU |-> span_r == ICT_CYC_ONE && $past(accept))
    else $error("Data processing did not retire after one cycle.");

  a_extend_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    retire && h_cls == ICT_EXTEND |-> span_r == ICT_CYC_ONE)
    else $error("Extension or reversal did not take one cycle.");

  a_pc_addr_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    retire && h_cls == ICT_ADDR_PC |-> span_r == ICT_CYC_ONE)
    else $error("Program counter address did not take one cycle.");

  a_sp_addr_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    retire && h_cls == ICT_ADDR_SP |-> span_r == ICT_CYC_ONE)
    else $error("Stack pointer arithmetic did not take one cycle.");

  a_ldst_two_cycles: assert property (@(posedge clk) disable iff (sys_rst)
    accept && issue_class == ICT_LDST |=> !issue_ready ##1 retire && issue_ready)
    else $error("Single load or store did not take two cycles.");

  a_multi_span: assert property (@(posedge clk) disable iff (sys_rst)
    retire && h_cls == ICT_MULTI |-> span_r == ICT_CYC_MULTI_BASE + {1'b0, h_n})
    else $error("Multiple transfer did not take one plus N cycles.");

  a_pop_ret_span: assert property (@(posedge clk) disable iff (sys_rst)
    retire && h_cls == ICT_POP_RET |-> span_r == ICT_CYC_POPRET_BASE + {1'b0, h_n})
    else $error("Pop with return did not take four plus N cycles.");

  a_cond_branch: assert property (@(posedge clk) disable iff (sys_rst)
    retire && h_cls == ICT_BR_COND |->
      span_r == (h_cond ? ICT_CYC_BR_TAKEN : ICT_CYC_BR_NOT))
    else $error("Conditional branch took the wrong number of cycles.");

  a_branch_cycles: assert property (@(posedge clk) disable iff (sys_rst)
    retire && (ict_plain_branch(h_cls) || h_cls == ICT_BR_LINK_IMM) |->
      span_r == (h_cls == ICT_BR_LINK_IMM ? ICT_CYC_BR_LINK : ICT_CYC_BRANCH))
    else $error("Branch took the wrong number of cycles.");

  a_sleep_own_cycles: assert property (@(posedge clk) disable iff (sys_rst)
    (retire && h_cls == ICT_SLEEP |-> span_r == ICT_CYC_SLEEP) and
    (sleeping |-> h_cls == ICT_SLEEP && !issue_ready))
    else $error("Sleep hint did not take two cycles of its own.");

  a_svc_config: assert property (@(posedge clk) disable iff (sys_rst)
    retire && h_cls == ICT_SVC |-> span_r == SVC_CYCLES[ICT_COST_W-1:0])
    else $error("Supervisor call did not take the configured cycles.");

  a_one_at_time: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(issue_ready) |-> retire && retire_cycles == span_r)
    else $error("Core became ready without retiring the instruction.");

endmodule

// *** ict_wake_src.sv ***
// Event source model that wakes a sleeping core promptly or after a delay.
`timescale 1ns/100ps
module ict_wake_src (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       sleeping,
  input  wire logic       early,
  input  wire logic [3:0] dly,
  output logic            wake
);
  logic [3:0] cnt_r;

  // Counts sleeping cycles so the wake level comes late, as a slow event would.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      cnt_r <= 4'h0;
    else if (!sleeping)
      cnt_r <= 4'h0;
    else if (cnt_r != dly)
      cnt_r <= cnt_r + 4'h1;
  end

  // An early event is already pending; otherwise wake only once the delay ran out.
  assign wake = early | (sleeping & (cnt_r == dly));
endmodule

// *** test_ict_timer.sv ***
// Self-checking bench for the instruction cycle timing block.
`timescale 1ns/100ps
module test_ict_timer;
  import ict_pkg::*;
  localparam int SVC_N = 6;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  issue_valid = 1'b0;
  ict_class_t            issue_class = ICT_ALU;
  logic [ICT_NREG_W-1:0] issue_nregs = 4'h0;
  logic                  cond_pass = 1'b0;
  logic                  early = 1'b1;
  logic                  wake;
  logic                  issue_ready;
  logic                  retire;
  logic                  sleeping;
  logic                  saw_sleep;
  ict_class_t            retire_class;
  logic [ICT_COST_W-1:0] retire_cycles;
  logic [4:0]            took;
  int                    n_errors = 0;
  int                    checks = 0;
  int                    cyc = 0;

  // Free-running core clock.
  always #12.5 clk = ~clk;

  ict_timer #(.SVC_CYCLES(SVC_N)) uut (
    .clk(clk), .sys_rst(sys_rst), .issue_valid(issue_valid),
    .issue_class(issue_class), .issue_nregs(issue_nregs), .cond_pass(cond_pass),
    .wake(wake), .issue_ready(issue_ready), .retire(retire),
    .retire_class(retire_class), .retire_cycles(retire_cycles), .sleeping(sleeping));

  ict_wake_src ws (.clk(clk), .sys_rst(sys_rst), .sleeping(sleeping),
    .early(early), .dly(4'h5), .wake(wake));

  // Compares a count or flag value.
  task automatic chk_cyc(input string what, input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Compares an instruction class.
  task automatic chk_cls(input ict_class_t exp, input ict_class_t got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED retire_class expected %0d seen %0d", exp, got);
    end
  endtask

  // Holds one request until taken, then counts cycles up to its retire pulse.
  task automatic cost(input ict_class_t c, input logic [3:0] n, input logic p,
                      input logic [4:0] exp);
    int k;
    issue_class = c;
    issue_nregs = n;
    cond_pass = p;
    issue_valid = 1'b1;
    k = 0;
    while (issue_ready !== 1'b1 && k < 64) begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    #1;
    issue_valid = 1'b0;
    k = 1;
    saw_sleep = 1'b0;
    while (retire !== 1'b1 && k < 64) begin
      saw_sleep |= sleeping;
      @(posedge clk);
      #1;
      k++;
    end
    took = k[4:0];
    chk_cls(c, retire_class);
    chk_cyc("retire_cycles", exp, retire_cycles);
  endtask

  // Single-cycle classes and single loads or stores, back to back.
  task automatic t_simple();
    cost(ICT_ALU, 4'h0, 1'b0, 5'h01);
    chk_cyc("cycles", 5'h01, took);
    cost(ICT_EXTEND, 4'h0, 1'b0, 5'h01);
    chk_cyc("cycles", 5'h01, took);
    cost(ICT_ADDR_PC, 4'h0, 1'b0, 5'h01);
    chk_cyc("cycles", 5'h01, took);
    cost(ICT_ADDR_SP, 4'h0, 1'b0, 5'h01);
    chk_cyc("cycles", 5'h01, took);
    cost(ICT_LDST, 4'h0, 1'b0, 5'h02);
    chk_cyc("cycles", 5'h02, took);
    $display("simple done");
  endtask

  // Multiple transfers and pop with return at register counts of 1 and 15.
  task automatic t_multi();
    cost(ICT_MULTI, 4'h1, 1'b0, 5'h02);
    chk_cyc("cycles", 5'h02, took);
    cost(ICT_MULTI, 4'hF, 1'b0, 5'h10);
    chk_cyc("cycles", 5'h10, took);
    cost(ICT_POP_RET, 4'h1, 1'b0, 5'h05);
    chk_cyc("cycles", 5'h05, took);
    cost(ICT_POP_RET, 4'hF, 1'b0, 5'h13);
    chk_cyc("cycles", 5'h13, took);
    $display("multi done");
  endtask

  // Every branch form, the conditional one both taken and not.
  task automatic t_branch();
    cost(ICT_BR_COND, 4'h0, 1'b1, 5'h03);
    chk_cyc("cycles", 5'h03, took);
    cost(ICT_BR_COND, 4'h0, 1'b0, 5'h01);
    chk_cyc("cycles", 5'h01, took);
    cost(ICT_BR_UNCOND, 4'h0, 1'b0, 5'h03);
    chk_cyc("cycles", 5'h03, took);
    cost(ICT_BR_REG, 4'h0, 1'b0, 5'h03);
    chk_cyc("cycles", 5'h03, took);
    cost(ICT_BR_LINK_REG, 4'h0, 1'b0, 5'h03);
    chk_cyc("cycles", 5'h03, took);
    cost(ICT_BR_LINK_IMM, 4'h0, 1'b0, 5'h04);
    chk_cyc("cycles", 5'h04, took);
    $display("branch done");
  endtask

  // Sleep with a pending event, then with a late one whose wait is not charged.
  task automatic t_sleep();
    cost(ICT_SLEEP, 4'h0, 1'b0, 5'h02);
    chk_cyc("cycles", 5'h02, took);
    early = 1'b0;
    cost(ICT_SLEEP, 4'h0, 1'b0, 5'h02);
    chk_cyc("slept", 5'h01, {4'h0, saw_sleep});
    chk_cyc("waited", 5'h01, {4'h0, took > 5'h02});
    early = 1'b1;
    $display("sleep done");
  endtask

  // Supervisor call charges the configured count.
  task automatic t_svc();
    cost(ICT_SVC, 4'h0, 1'b0, SVC_N[4:0]);
    chk_cyc("cycles", SVC_N[4:0], took);
    $display("svc done");
  endtask

  // A request held high is taken once per instruction, never while busy.
  task automatic t_hold(input ict_class_t c, input logic [4:0] exp);
    int r;
    r = 0;
    issue_class = c;
    issue_valid = 1'b1;
    repeat (4) begin
      @(posedge clk);
      #1;
      r += int'(retire);
    end
    issue_valid = 1'b0;
    chk_cyc("retires", exp, r[4:0]);
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Resets the core while a load is in flight, checks the idle values, then runs a load.
  task automatic t_reset();
    issue_class = ICT_LDST;
    issue_valid = 1'b1;
    @(posedge clk);
    #1;
    issue_valid = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk_cyc("ready", 5'h01, {4'h0, issue_ready});
    chk_cyc("retire", 5'h00, {4'h0, retire});
    chk_cyc("sleeping", 5'h00, {4'h0, sleeping});
    chk_cyc("retire_cycles", 5'h00, retire_cycles);
    chk_cls(ICT_ALU, retire_class);
    cost(ICT_LDST, 4'h0, 1'b0, 5'h02);
    chk_cyc("cycles", 5'h02, took);
    $display("reset done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk_cyc("ready", 5'h01, {4'h0, issue_ready});
    t_simple();
    t_multi();
    t_branch();
    t_sleep();
    t_svc();
    t_hold(ICT_ALU, 5'h04);
    t_hold(ICT_LDST, 5'h02);
    $display("order done");
    t_reset();
    stop_test();
  end
endmodule
